// File: logic/lptr_pkg.sv
// package: offsets, field layouts and reset values of the led timing / afe power bank
`default_nettype none
package lptr_pkg;
    // register indices as seen on the internal register port
    localparam logic [7:0] OFS_FIRST_PULSE  = 8'h31;
    localparam logic [7:0] OFS_LED_DISABLE  = 8'h34;
    localparam logic [7:0] OFS_SECOND_TIME  = 8'h35;
    localparam logic [7:0] OFS_SECOND_PULSE = 8'h36;
    localparam logic [7:0] OFS_CHAN_POWER   = 8'h37;
    localparam logic [7:0] OFS_FE_GLOBAL    = 8'h3C;
    // reset values, reserved fields included
    localparam logic [15:0] RST_FIRST_PULSE  = 16'h0818;
    localparam logic [15:0] RST_LED_DISABLE  = 16'h0000;
    localparam logic [15:0] RST_SECOND_TIME  = 16'h0320;
    localparam logic [15:0] RST_SECOND_PULSE = 16'h0818;
    localparam logic [15:0] RST_CHAN_POWER   = 16'h0000;
    localparam logic [15:0] RST_FE_GLOBAL    = 16'h3006;
    // field positions
    localparam int COUNT_LSB   = 8;
    localparam int PERIOD_LSB  = 0;
    localparam int MUTE_B_BIT  = 9;
    localparam int MUTE_A_BIT  = 8;
    localparam int WIDTH_LSB   = 8;
    localparam int DELAY_LSB   = 0;
    localparam int UPPER_LSB   = 13;
    localparam int CH2_LSB     = 10;
    localparam int EXT_B_LSB   = 8;
    localparam int EXT_A_LSB   = 0;
    localparam int CATHODE_BIT = 9;
    localparam int FE_PD_LSB   = 3;
    localparam int CH1_PD_LSB  = 3;
    localparam int GRP_PD_LSB  = 6;
    // timing step of the pulse fields
    localparam int STEP_NS        = 1000;
    localparam int CLK_PERIOD_NS  = 100;
    localparam int STEP_CYCLES    = (STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage
`default_nettype wire

// File: logic/lptr_power_map.sv
// module: maps channel power-down selects onto each amplifier of four channels
`timescale 1ns/10ps
`default_nettype none
module lptr_power_map (
    // clock and control
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       ce,
    // selects
    input  wire logic [5:0] frontend_channel_power_off,
    input  wire logic [2:0] second_channel_power_off,
    input  wire logic [2:0] upper_channels_power_off,
    // per channel power-down, bit 0 = channel one
    output logic      [3:0] transimpedance_amp_off,
    output logic      [3:0] bandpass_filter_amp_off,
    output logic      [3:0] integrator_amp_off
);
    logic [2:0] ch1;
    logic [2:0] grp;
    assign ch1 = frontend_channel_power_off[2:0]; // (R15)
    assign grp = frontend_channel_power_off[5:3]; // (R16)

    // one flop stage so the analog controls never see decode glitches
    always_ff @(posedge clk) begin
        if (rst) begin
            transimpedance_amp_off <= 4'h0;
            bandpass_filter_amp_off <= 4'h0;
            integrator_amp_off <= 4'h0;
        end else if (ce) begin
            transimpedance_amp_off <= {{2{grp[0] | upper_channels_power_off[0]}},
                                       grp[0] | second_channel_power_off[0], ch1[0]}; // (R13) (R14) (R15) (R16)
            bandpass_filter_amp_off <= {{2{grp[1] | upper_channels_power_off[1]}},
                                        grp[1] | second_channel_power_off[1], ch1[1]}; // (R13) (R14) (R15) (R16)
            integrator_amp_off <= {{2{grp[2] | upper_channels_power_off[2]}},
                                   grp[2] | second_channel_power_off[2], ch1[2]}; // (R13) (R14) (R15) (R16)
        end
    end
endmodule
`default_nettype wire

// File: logic/lptr_regs.sv
// module: led pulse timing and analog front end power register bank
//
// Behaviour
// (R1) first slot pulse count in upper byte, resets to eight
// (R2) first slot period low byte, microsecond units, resets to 0x18
// (R3) second slot pulse count in upper byte, resets to eight
// (R4) second slot period low byte, microsecond units, resets to 0x18
// (R5) channel power bits 1:0 extend first slot period, reset zero
// (R6) channel power bits 9:8 extend second slot period, reset zero
// (R7) second slot pulse width, five bits, microsecond steps, resets to three
// (R8) second slot delay to first pulse, microsecond steps, resets to 0x20
// (R9) second slot mute keeps driver powered, blocks its current pulses
// (R10) first slot mute blocks current pulses to its led, resets zero
// (R11) host turns slots off through slot enable, not mute bits
// (R12) host may mute both leds for a dark-level measurement
// (R13) channel power bits 15:13 power down channels three and four amps
// (R14) channel power bits 12:10 power down channel two amps
// (R15) global field zero keeps all on; bits 3..5 channel one amps
// (R16) global bits 6..8 power down one amp type on channels two to four
// (R17) cathode select zero: anode level; one: reverse bias; resets zero
// (R18) external cathode override enable takes precedence over cathode select
// (R19) host writes reserved fields only with their defaults
// (R20) sixteen-bit registers, reset defaults, timing applied at next slot start
`timescale 1ns/10ps
`default_nettype none
module lptr_regs (
    // clock and control
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    // register port from the host serial interface
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    output logic             reg_rd_valid,
    // slot sequencer events
    input  wire logic        first_slot_start,
    input  wire logic        second_slot_start,
    input  wire logic        first_slot_pulse_req,
    input  wire logic        second_slot_pulse_req,
    // active slot timing
    output logic      [7:0]  first_slot_pulse_count,
    output logic      [9:0]  first_slot_pulse_period,
    output logic      [7:0]  second_slot_pulse_count,
    output logic      [9:0]  second_slot_pulse_period,
    output logic      [4:0]  second_slot_pulse_width,
    output logic      [7:0]  second_slot_pulse_delay,
    output logic             step_tick,
    // led drivers
    output logic             first_slot_led_fire,
    output logic             second_slot_led_fire,
    output logic             first_slot_led_mute,
    output logic             second_slot_led_mute,
    // analog front end
    input  wire logic        bias_override_enable,
    output logic             cathode_reverse_bias,
    output logic             cathode_from_override,
    output logic      [3:0]  transimpedance_amp_off,
    output logic      [3:0]  bandpass_filter_amp_off,
    output logic      [3:0]  integrator_amp_off
);
    // full sixteen-bit storage, so reserved bits read back as written
    logic [15:0] first_slot_pulse_cfg;
    logic [15:0] led_disable_ctl;
    logic [15:0] second_slot_led_timing;
    logic [15:0] second_slot_pulse_cfg;
    logic [15:0] channel_power_period_ext;
    logic [15:0] frontend_global_cfg;
    logic [15:0] next_rdata;
    logic [$clog2(lptr_pkg::STEP_CYCLES + 1)-1:0] step_cnt;

    // address match helper used by both write and read decode
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    // register writes; unmapped addresses are ignored
    always_ff @(posedge clk) begin
        if (rst) begin
            first_slot_pulse_cfg <= lptr_pkg::RST_FIRST_PULSE; // (R1) (R2) (R20)
            led_disable_ctl <= lptr_pkg::RST_LED_DISABLE; // (R10) (R20)
            second_slot_led_timing <= lptr_pkg::RST_SECOND_TIME; // (R7) (R8) (R20)
            second_slot_pulse_cfg <= lptr_pkg::RST_SECOND_PULSE; // (R3) (R4) (R20)
            channel_power_period_ext <= lptr_pkg::RST_CHAN_POWER; // (R5) (R6) (R20)
            frontend_global_cfg <= lptr_pkg::RST_FE_GLOBAL; // (R15) (R17) (R20)
        end else if (ce && reg_wr) begin
            if (hit(reg_addr, lptr_pkg::OFS_FIRST_PULSE)) begin
                first_slot_pulse_cfg <= reg_wdata;
            end else if (hit(reg_addr, lptr_pkg::OFS_LED_DISABLE)) begin
                led_disable_ctl <= reg_wdata;
            end else if (hit(reg_addr, lptr_pkg::OFS_SECOND_TIME)) begin
                second_slot_led_timing <= reg_wdata;
            end else if (hit(reg_addr, lptr_pkg::OFS_SECOND_PULSE)) begin
                second_slot_pulse_cfg <= reg_wdata;
            end else if (hit(reg_addr, lptr_pkg::OFS_CHAN_POWER)) begin
                channel_power_period_ext <= reg_wdata;
            end else if (hit(reg_addr, lptr_pkg::OFS_FE_GLOBAL)) begin
                frontend_global_cfg <= reg_wdata;
            end
        end
    end

    // read decode; unmapped reads answer zero
    always_comb begin
        next_rdata = 16'h0000;
        if (hit(reg_addr, lptr_pkg::OFS_FIRST_PULSE)) begin
            next_rdata = first_slot_pulse_cfg;
        end else if (hit(reg_addr, lptr_pkg::OFS_LED_DISABLE)) begin
            next_rdata = led_disable_ctl;
        end else if (hit(reg_addr, lptr_pkg::OFS_SECOND_TIME)) begin
            next_rdata = second_slot_led_timing;
        end else if (hit(reg_addr, lptr_pkg::OFS_SECOND_PULSE)) begin
            next_rdata = second_slot_pulse_cfg;
        end else if (hit(reg_addr, lptr_pkg::OFS_CHAN_POWER)) begin
            next_rdata = channel_power_period_ext;
        end else if (hit(reg_addr, lptr_pkg::OFS_FE_GLOBAL)) begin
            next_rdata = frontend_global_cfg;
        end
    end

    // read data registered, valid one cycle after the request
    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
            reg_rd_valid <= 1'b0;
        end else if (ce) begin
            reg_rd_valid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= next_rdata;
            end
        end
    end

    // first slot timing, taken at the next first slot start
    lptr_slot_shadow #(
        .W    (18),
        .INIT ({lptr_pkg::RST_FIRST_PULSE[15:8], lptr_pkg::RST_CHAN_POWER[1:0],
                lptr_pkg::RST_FIRST_PULSE[7:0]})
    ) u_first_shadow (
        .clk    (clk),
        .rst    (rst),
        .ce     (ce),
        .live   ({first_slot_pulse_cfg[lptr_pkg::COUNT_LSB +: 8],
                  channel_power_period_ext[lptr_pkg::EXT_A_LSB +: 2],
                  first_slot_pulse_cfg[lptr_pkg::PERIOD_LSB +: 8]}), // (R1) (R2) (R5)
        .apply  (first_slot_start), // (R20)
        .active ({first_slot_pulse_count, first_slot_pulse_period})
    );

    // second slot timing: count, period, width and delay move together
    lptr_slot_shadow #(
        .W    (31),
        .INIT ({lptr_pkg::RST_SECOND_PULSE[15:8], lptr_pkg::RST_CHAN_POWER[9:8],
                lptr_pkg::RST_SECOND_PULSE[7:0], lptr_pkg::RST_SECOND_TIME[12:0]})
    ) u_second_shadow (
        .clk    (clk),
        .rst    (rst),
        .ce     (ce),
        .live   ({second_slot_pulse_cfg[lptr_pkg::COUNT_LSB +: 8],
                  channel_power_period_ext[lptr_pkg::EXT_B_LSB +: 2],
                  second_slot_pulse_cfg[lptr_pkg::PERIOD_LSB +: 8],
                  second_slot_led_timing[lptr_pkg::WIDTH_LSB +: 5],
                  second_slot_led_timing[lptr_pkg::DELAY_LSB +: 8]}), // (R3) (R4) (R6) (R7) (R8)
        .apply  (second_slot_start), // (R20)
        .active ({second_slot_pulse_count, second_slot_pulse_period,
                  second_slot_pulse_width, second_slot_pulse_delay})
    );

    // microsecond step tick for the sequencer counting the fields above
    always_ff @(posedge clk) begin
        if (rst) begin
            step_cnt <= '0;
            step_tick <= 1'b0;
        end else if (ce) begin
            step_tick <= (step_cnt == ($bits(step_cnt))'(lptr_pkg::STEP_CYCLES - 1));
            if (step_cnt == ($bits(step_cnt))'(lptr_pkg::STEP_CYCLES - 1)) begin
                step_cnt <= '0;
            end else begin
                step_cnt <= step_cnt + 1'b1;
            end
        end
    end

    // mute takes effect at once: the driver stays biased, only current is withheld
    assign first_slot_led_mute = led_disable_ctl[lptr_pkg::MUTE_A_BIT]; // (R10) (R12)
    assign second_slot_led_mute = led_disable_ctl[lptr_pkg::MUTE_B_BIT]; // (R9) (R12)

    // led fire: slot timing keeps running, the pulse request is just gated
    always_ff @(posedge clk) begin
        if (rst) begin
            first_slot_led_fire <= 1'b0;
            second_slot_led_fire <= 1'b0;
        end else if (ce) begin
            first_slot_led_fire <= first_slot_pulse_req & ~first_slot_led_mute; // (R10)
            second_slot_led_fire <= second_slot_pulse_req & ~second_slot_led_mute; // (R9)
        end
    end

    // cathode bias: external per-mode settings win while override is on
    always_ff @(posedge clk) begin
        if (rst) begin
            cathode_reverse_bias <= 1'b0;
            cathode_from_override <= 1'b0;
        end else if (ce) begin
            cathode_from_override <= bias_override_enable; // (R18)
            cathode_reverse_bias <= frontend_global_cfg[lptr_pkg::CATHODE_BIT] & ~bias_override_enable; // (R17) (R18)
        end
    end

    // amplifier power-down map
    lptr_power_map u_power_map (
        .clk                        (clk),
        .rst                        (rst),
        .ce                         (ce),
        .frontend_channel_power_off (frontend_global_cfg[lptr_pkg::FE_PD_LSB +: 6]), // (R15) (R16)
        .second_channel_power_off   (channel_power_period_ext[lptr_pkg::CH2_LSB +: 3]), // (R14)
        .upper_channels_power_off   (channel_power_period_ext[lptr_pkg::UPPER_LSB +: 3]), // (R13)
        .transimpedance_amp_off     (transimpedance_amp_off),
        .bandpass_filter_amp_off    (bandpass_filter_amp_off),
        .integrator_amp_off         (integrator_amp_off)
    );
endmodule
`default_nettype wire

// File: logic/lptr_slot_shadow.sv
// module: timing shadow that takes new slot settings only at a slot start
`timescale 1ns/10ps
`default_nettype none
module lptr_slot_shadow #(
    parameter int W = 8,
    parameter logic [W-1:0] INIT = '0
) (
    // clock and control
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         ce,
    // live value and apply strobe
    input  wire logic [W-1:0] live,
    input  wire logic         apply,
    // value used by the slot
    output logic      [W-1:0] active
);
    // a write mid-slot must not bend the pulses already running
    always_ff @(posedge clk) begin
        if (rst) begin
            active <= INIT;
        end else if (ce && apply) begin
            active <= live;
        end
    end
endmodule
`default_nettype wire

// File: tb/lptr_regs_bench.sv
// bench: register access, slot shadows, mutes, power map and cathode tests
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; \
    $display("wrong value %s exp %h got %h", n, e, g); end end
module lptr_regs_bench;
    logic        clk = 1'b0, rst = 1'b1, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, bias_override_enable = 1'b0;
    logic        first_slot_start = 1'b0, second_slot_start = 1'b0;
    logic        first_slot_pulse_req = 1'b0, second_slot_pulse_req = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata;
    logic        reg_rd_valid, step_tick, first_slot_led_fire, second_slot_led_fire;
    logic        first_slot_led_mute, second_slot_led_mute, cathode_reverse_bias, cathode_from_override;
    logic [7:0]  first_slot_pulse_count, second_slot_pulse_count, second_slot_pulse_delay;
    logic [9:0]  first_slot_pulse_period, second_slot_pulse_period;
    logic [4:0]  second_slot_pulse_width;
    logic [3:0]  transimpedance_amp_off, bandpass_filter_amp_off, integrator_amp_off;
    int          fail_count = 0, check_count = 0;
    logic [7:0]  ofs [6] = '{lptr_pkg::OFS_FIRST_PULSE, lptr_pkg::OFS_LED_DISABLE, lptr_pkg::OFS_SECOND_TIME,
                             lptr_pkg::OFS_SECOND_PULSE, lptr_pkg::OFS_CHAN_POWER, lptr_pkg::OFS_FE_GLOBAL};
    logic [15:0] rstv [6] = '{16'h0818, 16'h0000, 16'h0320, 16'h0818, 16'h0000, 16'h3006};
    logic [5:0]  fe [3] = '{6'h07, 6'h08, 6'h30};
    logic [15:0] cp [3] = '{16'h0000, 16'h8800, 16'h2400};
    logic [3:0]  e_tia [3] = '{4'h1, 4'hE, 4'hE};
    logic [3:0]  e_bpf [3] = '{4'h1, 4'h2, 4'hE};
    logic [3:0]  e_int [3] = '{4'h1, 4'hC, 4'hE};
    // 10 MHz clock
    always #50 clk = ~clk;
    lptr_regs u_lptr_regs (.clk, .rst, .ce, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .reg_rd_valid,
        .first_slot_start, .second_slot_start, .first_slot_pulse_req, .second_slot_pulse_req,
        .first_slot_pulse_count, .first_slot_pulse_period, .second_slot_pulse_count, .second_slot_pulse_period,
        .second_slot_pulse_width, .second_slot_pulse_delay, .step_tick, .first_slot_led_fire,
        .second_slot_led_fire, .first_slot_led_mute, .second_slot_led_mute, .bias_override_enable,
        .cathode_reverse_bias, .cathode_from_override, .transimpedance_amp_off, .bandpass_filter_amp_off,
        .integrator_amp_off);
    // one write strobe, held over one rising edge
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask
    // read strobe, answer looked at in its single valid cycle
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        `CHK("rd_valid", 1'b1, reg_rd_valid)
        `CHK("rdata", e, reg_rdata)
    endtask
    // one-cycle slot start pulse
    task automatic start_slot(input logic second);
        @(negedge clk);
        first_slot_start = !second;
        second_slot_start = second;
        @(negedge clk);
        first_slot_start = 1'b0;
        second_slot_start = 1'b0;
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // watchdog, tests need well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        fail_count++;
        end_sim();
    end
    initial begin
        repeat (6) @(negedge clk);
        rst = 1'b0;
        for (int i = 0; i < 6; i++) begin
            wr(ofs[i], 16'hA5C3 ^ {12'h000, i[3:0]});
            rd(ofs[i], 16'hA5C3 ^ {12'h000, i[3:0]});
        end
        wr(8'h32, 16'h1234);
        rd(8'h32, 16'h0000);
        rd(ofs[0], 16'hA5C3);
        $display("test readback done");
        // second reset in mid-run restores every default
        rst = 1'b1;
        repeat (6) @(negedge clk);
        rst = 1'b0;
        for (int i = 0; i < 6; i++) rd(ofs[i], rstv[i]);
        `CHK("delay", 8'h20, second_slot_pulse_delay)
        `CHK("period_a", 10'h018, first_slot_pulse_period)
        `CHK("period_b", 10'h018, second_slot_pulse_period)
        `CHK("width_b", 5'h03, second_slot_pulse_width)
        `CHK("amps", 12'h000, {transimpedance_amp_off, bandpass_filter_amp_off, integrator_amp_off})
        $display("test reset done");
        wr(8'h37, 16'h0201);
        wr(8'h31, 16'h0420);
        wr(8'h36, 16'h0533);
        wr(8'h35, 16'h1F07);
        `CHK("count_a", 8'h08, first_slot_pulse_count)
        `CHK("period_a", 10'h018, first_slot_pulse_period)
        start_slot(1'b0);
        `CHK("count_a", 8'h04, first_slot_pulse_count)
        `CHK("period_a", 10'h120, first_slot_pulse_period)
        `CHK("count_b", 8'h08, second_slot_pulse_count)
        start_slot(1'b1);
        `CHK("count_b", 8'h05, second_slot_pulse_count)
        `CHK("period_b", 10'h233, second_slot_pulse_period)
        `CHK("width_b", 5'h1F, second_slot_pulse_width)
        `CHK("delay_b", 8'h07, second_slot_pulse_delay)
        $display("test slot timing done");
        first_slot_pulse_req = 1'b1;
        second_slot_pulse_req = 1'b1;
        // mute value 3 mutes both leds for a dark-level run
        for (int m = 0; m < 4; m++) begin
            wr(8'h34, {6'h00, m[1:0], 8'h00});
            @(negedge clk);
            `CHK("mute", m[1:0], {second_slot_led_mute, first_slot_led_mute})
            `CHK("fire", ~m[1:0], {second_slot_led_fire, first_slot_led_fire})
        end
        first_slot_pulse_req = 1'b0;
        second_slot_pulse_req = 1'b0;
        $display("test mute done");
        for (int c = 0; c < 3; c++) begin
            wr(8'h3C, 16'h3006 | {7'h00, fe[c], 3'h0});
            wr(8'h37, cp[c]);
            @(negedge clk);
            `CHK("tia", e_tia[c], transimpedance_amp_off)
            `CHK("bpf", e_bpf[c], bandpass_filter_amp_off)
            `CHK("int", e_int[c], integrator_amp_off)
        end
        $display("test power map done");
        wr(8'h3C, 16'h3206);
        @(negedge clk);
        `CHK("reverse", 1'b1, cathode_reverse_bias)
        bias_override_enable = 1'b1;
        @(negedge clk);
        `CHK("reverse", 1'b0, cathode_reverse_bias)
        `CHK("override", 1'b1, cathode_from_override)
        bias_override_enable = 1'b0;
        $display("test cathode done");
        ce = 1'b0;
        wr(8'h31, 16'hFFFF);
        ce = 1'b1;
        rd(8'h31, 16'h0420);
        $display("test clock enable done");
        end_sim();
    end
endmodule
`default_nettype wire

// File: tb/lptr_regs_sva.sv
// checker: port-level assertions for the led timing and front end power bank
`timescale 1ns/10ps
`default_nettype none
module lptr_regs_sva (
    // clock and control
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       ce,
    // register port
    input wire logic       reg_rd,
    input wire logic       reg_rd_valid,
    // slot timing
    input wire logic       first_slot_start,
    input wire logic       second_slot_start,
    input wire logic [7:0] first_slot_pulse_count,
    input wire logic [4:0] second_slot_pulse_width,
    input wire logic       step_tick,
    // led drivers
    input wire logic       first_slot_pulse_req,
    input wire logic       second_slot_pulse_req,
    input wire logic       first_slot_led_fire,
    input wire logic       second_slot_led_fire,
    input wire logic       first_slot_led_mute,
    input wire logic       second_slot_led_mute,
    // cathode
    input wire logic       bias_override_enable,
    input wire logic       cathode_reverse_bias,
    input wire logic       cathode_from_override
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // multi-step behaviours
    sequence rd_taken;
        ce && reg_rd;
    endsequence
    sequence tick_gap;
        (!step_tick)[*8] ##1 !step_tick ##1 step_tick;
    endsequence
    rd_valid_a: assert property (rd_taken |=> reg_rd_valid) else $error("read not answered");
    rd_single_a: assert property (ce && !reg_rd |=> !reg_rd_valid) else $error("stray read valid");
    fire_first_a: assert property (ce && first_slot_pulse_req && !first_slot_led_mute |=> first_slot_led_fire)
        else $error("first led did not fire");
    mute_first_a: assert property (ce && first_slot_led_mute |=> !first_slot_led_fire)
        else $error("muted first led fired");
    fire_second_a: assert property (ce && second_slot_pulse_req && !second_slot_led_mute |=> second_slot_led_fire)
        else $error("second led did not fire");
    mute_second_a: assert property (ce && second_slot_led_mute |=> !second_slot_led_fire)
        else $error("muted second led fired");
    count_hold_a: assert property (ce && !first_slot_start |=> $stable(first_slot_pulse_count))
        else $error("count changed between slot starts");
    width_hold_a: assert property (ce && !second_slot_start |=> $stable(second_slot_pulse_width))
        else $error("width changed between slot starts");
    override_wins_a: assert property (ce && bias_override_enable |=> !cathode_reverse_bias && cathode_from_override)
        else $error("override did not take precedence");
    // ce low freezes the tick counter, so the spacing is only checked while running
    tick_step_a: assert property (@(posedge clk) disable iff (rst || !ce) step_tick |=> tick_gap)
        else $error("tick spacing wrong");
    reset_value_a: assert property (@(posedge clk) disable iff (!ce) rst && ce |=> first_slot_pulse_count == 8'h08)
        else $error("count not reset");
endmodule
bind lptr_regs lptr_regs_sva u_lptr_regs_sva (.clk, .rst, .ce, .reg_rd, .reg_rd_valid, .first_slot_start,
    .second_slot_start, .first_slot_pulse_count, .second_slot_pulse_width, .step_tick, .first_slot_pulse_req,
    .second_slot_pulse_req, .first_slot_led_fire, .second_slot_led_fire, .first_slot_led_mute,
    .second_slot_led_mute, .bias_override_enable, .cathode_reverse_bias, .cathode_from_override);
`default_nettype wire
